// *** rtl/branch_increment_exec.sv ***
// execute stage for the unconditional jump and the two increment forms
// assumes the core presents one fetched word per instruction-cycle enable
// and supplies the addressed register value combinationally.
// Contract
// - top bits 101 decode as eleven-bit jump
// - jump literal loads counter bits ten to zero
// - counter bits 12:11 from latch bits 4:3
// - jump takes two cycles, flags unchanged
// - increment adds one, updates zero flag
// - destination bit zero picks working register
// - increment-skip writes result, flags untouched
// - zero result discards prefetched instruction
// - skip executes no-operation, two cycles total
`timescale 1ns/1ns
module branch_increment_exec (
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst_b,
  // instruction cycle
  input  wire logic                   cycle_en,
  input  wire logic [13:0]            instr_word,
  // core state
  input  wire logic [7:0]             file_rdata,
  input  wire logic [7:0]             upper_address_latch,
  // results
  output logic      [12:0]            program_counter,
  output logic      [6:0]             file_addr,
  output logic      [7:0]             file_wdata,
  output logic                        file_we,
  output logic      [7:0]             work_wdata,
  output logic                        work_we,
  output logic                        zero_flag_we,
  output logic                        zero_flag_val,
  output logic                        flush_busy
);
  typedef enum logic [1:0] {
    EXEC  = 2'b01,
    FLUSH = 2'b10
  } state_type;

  // incrementer wraps at 8 bits on purpose
  function automatic logic [7:0] inc8(input logic [7:0] v);
    inc8 = v + branch_increment_pkg::ONE;
  endfunction

  state_type         state_ff, nxt_state;
  logic [12:0]       pc_ff, nxt_pc;
  logic [6:0]        faddr_ff;
  logic [7:0]        fwd_ff, wwd_ff;
  logic              fwe_ff, wwe_ff, zwe_ff, zval_ff;

  // decode wires
  wire logic         is_jump  = instr_word[13:11] ==
                                branch_increment_pkg::JUMP_OP;
  wire logic         is_inc   = instr_word[13:8] ==
                                branch_increment_pkg::INC_OP;
  wire logic         is_iskip = instr_word[13:8] ==
                                branch_increment_pkg::INCSKIP_OP;
  wire logic         dest_f   = instr_word[branch_increment_pkg::DEST_BIT];
  wire logic [7:0]   inc_res  = inc8(file_rdata);
  wire logic         res_zero = inc_res == 8'h00;
  wire logic         executing = cycle_en && state_ff == EXEC;
  wire logic         any_inc  = executing && (is_inc || is_iskip);
  // jump target: latch bits above, literal below
  wire logic [12:0]  jump_pc  = {upper_address_latch[
                                   branch_increment_pkg::LATCH_HI:
                                   branch_increment_pkg::LATCH_LO],
                                 instr_word[10:0]};

  // next state: jump and zero skip both spend one flush cycle
  always_comb begin
    nxt_state = state_ff;
    nxt_pc = pc_ff;
    if (cycle_en) begin
      unique case (state_ff)
        EXEC: begin
          if (is_jump) begin
            nxt_pc = jump_pc;
            nxt_state = FLUSH;
          end else if (is_iskip && res_zero) begin
            nxt_pc = 13'(pc_ff + 13'h0002);
            nxt_state = FLUSH;
          end else begin
            nxt_pc = 13'(pc_ff + 13'h0001);
          end
        end
        FLUSH: begin
          // fetched word is ignored; acts as no-operation
          nxt_state = EXEC;
        end
        default: nxt_state = EXEC;
      endcase
    end
  end

  // state and counter
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= EXEC;
      pc_ff <= branch_increment_pkg::PC_RESET;
    end else begin
      state_ff <= nxt_state;
      pc_ff <= nxt_pc;
    end
  end

  // write strobes; flush cycle writes nothing
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      faddr_ff <= 7'h00;
      fwd_ff <= 8'h00;
      wwd_ff <= 8'h00;
      fwe_ff <= 1'b0;
      wwe_ff <= 1'b0;
      zwe_ff <= 1'b0;
      zval_ff <= 1'b0;
    end else begin
      faddr_ff <= instr_word[6:0];
      fwd_ff <= inc_res;
      wwd_ff <= inc_res;
      fwe_ff <= any_inc && dest_f;
      wwe_ff <= any_inc && !dest_f;
      zwe_ff <= executing && is_inc;
      zval_ff <= res_zero;
    end
  end

  assign program_counter = pc_ff;
  assign file_addr = faddr_ff;
  assign file_wdata = fwd_ff;
  assign file_we = fwe_ff;
  assign work_wdata = wwd_ff;
  assign work_we = wwe_ff;
  assign zero_flag_we = zwe_ff;
  assign zero_flag_val = zval_ff;
  // one-hot, so the flush bit of the state flop drives the pin directly
  assign flush_busy = state_ff[1];

  property p_jump_target;
    @(posedge core_clk) disable iff (!rst_b)
      (executing && is_jump) |=> program_counter == $past(jump_pc);
  endproperty
  a_jump_target: assert property (p_jump_target)
    else $error("jump target wrong");

  property p_jump_upper;
    @(posedge core_clk) disable iff (!rst_b)
      (executing && is_jump) |=>
        program_counter[12:11] == $past(upper_address_latch[4:3]);
  endproperty
  a_jump_upper: assert property (p_jump_upper)
    else $error("jump upper bits wrong");

  property p_jump_two;
    @(posedge core_clk) disable iff (!rst_b)
      (executing && is_jump) |=> flush_busy && !zero_flag_we;
  endproperty
  a_jump_two: assert property (p_jump_two)
    else $error("jump not two cycles");

  property p_inc_zero;
    @(posedge core_clk) disable iff (!rst_b)
      (executing && is_inc) |=>
        zero_flag_we && zero_flag_val == (file_wdata == 8'h00);
  endproperty
  a_inc_zero: assert property (p_inc_zero)
    else $error("increment zero flag wrong");

  property p_dest;
    @(posedge core_clk) disable iff (!rst_b)
      any_inc |=> (file_we == $past(dest_f)) && (work_we != file_we);
  endproperty
  a_dest: assert property (p_dest)
    else $error("increment destination wrong");

  property p_skip_noflag;
    @(posedge core_clk) disable iff (!rst_b)
      (executing && is_iskip) |=> !zero_flag_we;
  endproperty
  a_skip_noflag: assert property (p_skip_noflag)
    else $error("skip touched flag");

  property p_skip_flush;
    @(posedge core_clk) disable iff (!rst_b)
      (executing && is_iskip && res_zero) |=> flush_busy;
  endproperty
  a_skip_flush: assert property (p_skip_flush)
    else $error("skip did not discard");

  property p_flush_nop;
    @(posedge core_clk) disable iff (!rst_b)
      (flush_busy && cycle_en) |=>
        !file_we && !work_we && !zero_flag_we && !flush_busy;
  endproperty
  a_flush_nop: assert property (p_flush_nop)
    else $error("flush cycle not a no-operation");

  property p_wrap;
    @(posedge core_clk) disable iff (!rst_b)
      (any_inc && file_rdata == 8'hff) |=> file_wdata == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("increment did not wrap");

  property p_skip_pc;
    @(posedge core_clk) disable iff (!rst_b)
      (executing && is_iskip && res_zero) |=>
        program_counter == 13'($past(program_counter) + 13'h0002);
  endproperty
  a_skip_pc: assert property (p_skip_pc)
    else $error("skip did not step over the next word");

  property p_flush_hold;
    @(posedge core_clk) disable iff (!rst_b)
      (flush_busy && cycle_en) |=> $stable(program_counter);
  endproperty
  a_flush_hold: assert property (p_flush_hold)
    else $error("discarded word moved the counter");

  property p_inc_value;
    @(posedge core_clk) disable iff (!rst_b)
      any_inc |=> file_wdata == 8'($past(file_rdata) + 8'h01);
  endproperty
  a_inc_value: assert property (p_inc_value)
    else $error("increment result wrong");

  property p_jump_nowrite;
    @(posedge core_clk) disable iff (!rst_b)
      (executing && is_jump) |=> !file_we && !work_we;
  endproperty
  a_jump_nowrite: assert property (p_jump_nowrite)
    else $error("jump wrote a register");
endmodule // branch_increment_exec

// *** shared/branch_increment_pkg.sv ***
// constants for the jump and increment execute block
// assumes a 14-bit instruction word and 8-bit data registers
package branch_increment_pkg;
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int PC_W = 13;
  localparam int FADDR_W = 7;
  localparam int LIT_W = 11;
  // opcode fields
  localparam logic [2:0] JUMP_OP = 3'h5;
  localparam logic [5:0] INC_OP = 6'h0a;
  localparam logic [5:0] INCSKIP_OP = 6'h0f;
  // field positions inside the instruction word and the upper address latch
  localparam int DEST_BIT = 7;
  localparam int LATCH_LO = 3;
  localparam int LATCH_HI = 4;
  // reset value and increment step
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [DATA_W-1:0] ONE = 8'h01;
endpackage

// *** testbench/branch_increment_exec_tb_top.sv ***
// self-checking bench for the jump and increment execute block
// assumes the block answers one clock after a taken instruction cycle
`timescale 1ns/1ns
module branch_increment_exec_tb_top;
  logic        core_clk, rst_b, cycle_en, file_we, work_we;
  logic        zero_flag_we, zero_flag_val, flush_busy;
  logic [13:0] instr_word;
  logic [7:0]  file_rdata, upper_address_latch, file_wdata, work_wdata;
  logic [12:0] program_counter, exp_pc;
  logic [6:0]  file_addr;
  int          n_mismatch, samples_checked, cyc;

  branch_increment_exec u_dut (.core_clk(core_clk), .rst_b(rst_b),
    .cycle_en(cycle_en), .instr_word(instr_word), .file_rdata(file_rdata),
    .upper_address_latch(upper_address_latch),
    .program_counter(program_counter), .file_addr(file_addr),
    .file_wdata(file_wdata), .file_we(file_we), .work_wdata(work_wdata),
    .work_we(work_we), .zero_flag_we(zero_flag_we),
    .zero_flag_val(zero_flag_val), .flush_busy(flush_busy));

  // clock at 8 ns; the cycle ceiling cuts a hang short
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk_val(input logic [12:0] got, input logic [12:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t value %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t flag %b exp %b", $time, got, exp);
    end
  endtask
  // one taken cycle; outputs are sampled once the answer edge settled
  task automatic step(input logic [13:0] w, input logic [7:0] d);
    @(posedge core_clk);
    cycle_en <= 1'b1;
    instr_word <= w;
    file_rdata <= d;
    @(posedge core_clk);
    cycle_en <= 1'b0;
    #1;
  endtask
  task automatic strobes(input logic f, w, z, b);
    chk_flag(file_we, f);
    chk_flag(work_we, w);
    chk_flag(zero_flag_we, z);
    chk_flag(flush_busy, b);
  endtask
  // plain increment of all ones wraps to zero, result back to register
  task automatic t_inc_wrap();
    step({branch_increment_pkg::INC_OP, 8'h85}, 8'hff);
    exp_pc = exp_pc + 13'h0001;
    strobes(1'b1, 1'b0, 1'b1, 1'b0);
    chk_val(13'(file_wdata), 13'h0000);
    chk_val(13'(file_addr), 13'h0005);
    chk_flag(zero_flag_val, 1'b1);
    chk_val(program_counter, exp_pc);
  endtask
  // destination bit low routes to the working register, zero flag clear
  task automatic t_inc_work();
    step({branch_increment_pkg::INC_OP, 8'h7f}, 8'h41);
    exp_pc = exp_pc + 13'h0001;
    strobes(1'b0, 1'b1, 1'b1, 1'b0);
    chk_val(13'(work_wdata), 13'h0042);
    chk_flag(zero_flag_val, 1'b0);
  endtask
  // skip form: no flag update; zero result discards the next word;
  // the zero case writes back to the register, the other to working
  task automatic t_skip(input logic [7:0] d, input logic z);
    step({branch_increment_pkg::INCSKIP_OP, z, 7'h03}, d);
    exp_pc = exp_pc + (z ? 13'h0002 : 13'h0001);
    strobes(z, !z, 1'b0, z);
    chk_val(13'(z ? file_wdata : work_wdata),
            {5'h00, 8'(d + 8'h01)});
    chk_val(program_counter, exp_pc);
    if (z) flush_check();
  endtask
  // jump target from literal and latch bits 4:3, then one dead cycle
  task automatic t_jump(input logic [7:0] l, input logic [10:0] k);
    @(posedge core_clk);
    upper_address_latch <= l;
    step({branch_increment_pkg::JUMP_OP, k}, 8'h00);
    exp_pc = {l[4:3], k};
    strobes(1'b0, 1'b0, 1'b0, 1'b1);
    chk_val(program_counter, exp_pc);
    flush_check();
  endtask
  // a word offered in the dead cycle raises no write strobe and leaves the counter alone
  task automatic flush_check();
    step({branch_increment_pkg::INC_OP, 8'h85}, 8'h10);
    strobes(1'b0, 1'b0, 1'b0, 1'b0);
    chk_val(program_counter, exp_pc);
  endtask

  initial begin
    rst_b = 1'b0;
    cycle_en = 1'b0;
    instr_word = 14'h0000;
    file_rdata = 8'h00;
    upper_address_latch = 8'h00;
    exp_pc = 13'h0000;
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    t_inc_wrap();
    t_inc_work();
    t_skip(8'h10, 1'b0);
    t_skip(8'hff, 1'b1);
    t_jump(8'hf7, 11'h7ff);
    t_jump(8'he8, 11'h000);
    t_inc_wrap();
    stop_test();
  end
endmodule // branch_increment_exec_tb_top
